// >>> inc/t3e3_alarm_pkg.sv
// Constants, register map and carrier types for the receive alarm block.
// Assumes a byte-addressed register bus with one 32-bit word per register.
package t3e3_alarm_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_ALARM_STATUS = 8'h12;
  localparam logic [7:0] IDX_ALARM_MASK = 8'h14;
  localparam logic [7:0] IDX_EVENT_INFO = 8'h16;
  localparam logic [7:0] IDX_MASTER_MASK = 8'h18;
  localparam int ADDR_W = 10;

  // Alarm status and mask bit positions
  localparam int ST_LOS = 0;
  localparam int ST_LOF = 1;
  localparam int ST_AIS = 2;
  localparam int ST_RAI = 3;
  localparam int ST_IDLE = 4;
  localparam int ST_TX_FRAME_START = 5;
  localparam int ST_RX_FRAME_START = 6;
  localparam int MASK_BITS = 7;

  // Event information bit positions
  localparam int IN_ALIGNMENT_CHANGED = 0;
  localparam int IN_SEVERE_FRAMING_EVENT = 5;
  localparam int IN_SN = 8;
  localparam int IN_AIC = 9;
  localparam int IN_SIGNAL_RESTORED = 10;
  localparam int IN_FAR_END_ALARM_CLEARED = 13;

  // Values after reset
  localparam logic [15:0] RESET_ALARM_MASK = 16'h0080;
  localparam logic RESET_MASTER_MASK = 1'b0;

  // Detection counts
  localparam logic [10:0] FIELD_RUN_LEN = 11'h400;
  localparam logic [2:0] FIELD_ERR_LIMIT = 3'h4;
  localparam logic [7:0] LOS_ZERO_RUN = 8'hC0;
  localparam logic [7:0] LOS_WINDOW_BITS = 8'hC0;
  localparam logic [7:0] T3_EXZ_RUN = 8'h03;
  localparam logic [7:0] E3_EXZ_RUN = 8'h04;
  localparam logic [4:0] F_ERR_LIMIT = 5'h03;
  localparam logic [4:0] M_ERR_LIMIT = 5'h02;
  localparam logic [2:0] RAI_RUN = 3'h4;
  localparam logic [3:0] E3_AIS_MAX_ZEROS = 4'h4;
  localparam logic [2:0] E3_ZERO_SAT = 3'h5;
  localparam logic [2:0] E3_LOF_BAD = 3'h4;
  localparam logic [2:0] E3_LOF_GOOD = 3'h3;
  localparam logic [2:0] C_SUBFRAME_IDLE = 3'h3;
  localparam logic [1:0] C_LAST_IDX = 2'h2;
  localparam int ALIGN_W = 11;

  // One received bit and its position within the frame
  typedef struct packed {
    logic bitValid;
    logic bitVal;
    logic payload;
    logic fieldStart;
    logic fieldEnd;
  } rx_bit_s;

  // Overhead strobes from the frame aligner
  typedef struct packed {
    logic frameStart;
    logic fStrobe;
    logic fErr;
    logic mStrobe;
    logic mErr;
    logic xStrobe;
    logic x1;
    logic x2;
    logic cStrobe;
    logic cVal;
    logic [1:0] cIdx;
    logic [2:0] subframe;
    logic fasStrobe;
    logic fasGood;
    logic bit11Strobe;
    logic bit11;
    logic snBit;
  } ovh_s;

endpackage

// >>> hw/zero_run_detect.sv
// Zero-run watcher: excess-zero events and signal absence.
// Assumes bits arrive with bitValid on the receive clock.
`timescale 1ns/1ps
module zero_run_detect import t3e3_alarm_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic bitValid,
  input wire logic bitVal,
  input wire logic e3Mode,
  input wire logic bipolarLine,
  output logic signalAbsent,
  output logic zeroRunExcess
);
  typedef enum logic [1:0] {LOS_CLEAR, LOS_DECLARED, LOS_WINDOW} los_state_e;

  los_state_e state_r, state_nxt;
  logic [7:0] zeroRun_r, zeroRun_nxt;
  logic [7:0] winCnt_r, winCnt_nxt;
  logic exz_r, exz_nxt;
  logic [7:0] runLimit;
  logic exzNow;

  assign runLimit = e3Mode ? E3_EXZ_RUN : T3_EXZ_RUN;

  always_comb begin
    state_nxt = state_r;
    zeroRun_nxt = zeroRun_r;
    winCnt_nxt = winCnt_r;
    exzNow = 1'b0;
    if (bitValid) begin
      if (bitVal) begin
        zeroRun_nxt = 8'h00;
      end else if (zeroRun_r != LOS_ZERO_RUN) begin
        zeroRun_nxt = zeroRun_r + 8'h01;
      end
      // One event per run, however long the run
      exzNow = !bitVal && (zeroRun_r + 8'h01 == runLimit);
      unique case (state_r)
        LOS_CLEAR: begin
          if (!bitVal && (zeroRun_r + 8'h01 == LOS_ZERO_RUN)) begin
            state_nxt = LOS_DECLARED;
          end
        end
        LOS_DECLARED: begin
          if (bitVal) begin
            state_nxt = LOS_WINDOW;
            winCnt_nxt = 8'h01;
          end
        end
        LOS_WINDOW: begin
          if (exzNow) begin
            state_nxt = LOS_DECLARED;
          end else if (winCnt_r + 8'h01 == LOS_WINDOW_BITS) begin
            state_nxt = LOS_CLEAR;
          end else begin
            winCnt_nxt = winCnt_r + 8'h01;
          end
        end
        default: state_nxt = LOS_CLEAR;
      endcase
    end
    exz_nxt = exzNow;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= LOS_CLEAR;
      zeroRun_r <= 8'h00;
      winCnt_r <= 8'h00;
      exz_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      zeroRun_r <= zeroRun_nxt;
      winCnt_r <= winCnt_nxt;
      exz_r <= exz_nxt;
    end
  end

  // Undefined on a unipolar line, so held inactive there
  assign signalAbsent = bipolarLine && (state_r != LOS_CLEAR);
  assign zeroRunExcess = exz_r;
endmodule

// >>> hw/t3e3_alarm_detect_status.sv
// Receive alarm detection, status latches, masks and event information.
// Assumes the frame aligner supplies bit and overhead strobes on ref_clk.
//
// Function
// - Each mask bit set enables, cleared blocks, its status condition's interrupt.
// - One read of the alarm status clears each latch it returned set whose condition is gone.
// - T3 upstream alarm: 1024 fields with under 4 errors of 10 pattern, C bits zero.
// - T3 upstream alarm clears after 1024 fields with 4 or more errors.
// - Signal absent after 192 zeros; clears on clean 192-bit window from a one.
// - Signal absent has no meaning on a unipolar line.
// - T3 frame lost on 3 of 16 F errors or 2 of 4 M errors.
// - T3 far-end alarm set on X bits zero 4 frames, cleared on one 4 frames.
// - T3 idle: 1024 fields with under 4 errors of 1100, subframe 3 C zero.
// - T3 idle clears after 1024 fields with 4 or more errors.
// - E3 upstream alarm on at most 4 zeros in two frames, clears at 5.
// - E3 far-end alarm on bit 11 one 4 frames, cleared on zero 4 frames.
// - In C-bit parity mode alarm channel codes also raise far-end alarm.
// - No event information bit ever drives the interrupt.
// - Alignment change latched on resync at new alignment, only after first sync.
// - Alignment change clears on read, sets again on any later resync at a new alignment.
// - Alarm bits latch on condition; a read clears them only once gone.
// - Status change or frame start interrupts only with own and master mask set.
// - Excess-zero event on 3 zeros in T3 or 4 zeros in E3.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
module t3e3_alarm_detect_status import t3e3_alarm_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire rx_bit_s rxBit,
  input wire ovh_s ovh,
  input wire logic e3Mode,
  input wire logic bipolarLine,
  input wire logic cbitParity,
  input wire logic feacRai,
  input wire logic txFrameStart,
  input wire logic zeroSubWord,
  input wire logic appIdChannel,
  input wire logic syncAchieved,
  input wire logic [ALIGN_W-1:0] syncAlign,
  output logic irq,
  output logic signalAbsent,
  output logic frameLost,
  output logic upstreamAlarm,
  output logic farEndAlarm,
  output logic idlePatternSeen
);

  function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    regHit = (a == {idx, 2'b00});
  endfunction

  function automatic logic [4:0] ones16(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, v[i]};
    end
    ones16 = n;
  endfunction

  function automatic logic [2:0] inc3(input logic [2:0] v, input logic [2:0] lim);
    inc3 = (v == lim) ? v : v + 3'h1;
  endfunction

  function automatic logic [10:0] runInc(input logic [10:0] v);
    runInc = (v == FIELD_RUN_LEN) ? v : v + 11'h001;
  endfunction

  function automatic logic [2:0] errInc(input logic [2:0] v, input logic miss);
    errInc = (miss && v != FIELD_ERR_LIMIT) ? v + 3'h1 : v;
  endfunction

  // Bus state
  logic ackR, ackNxt;
  logic [31:0] readdataR, readdataNxt;
  logic [MASK_BITS-1:0] maskR, maskNxt;
  logic masterR, masterNxt;
  logic req, accept, stsClr, infoClr;

  // Detector state
  logic [15:0] fHist_r, fHist_nxt;
  logic [3:0] mHist_r, mHist_nxt;
  logic [2:0] fasBad_r, fasBad_nxt, fasGood_r, fasGood_nxt;
  logic lof_r, lof_nxt;
  logic [1:0] bitIdx_r, bitIdx_nxt;
  logic [2:0] aisErr_r, aisErr_nxt, idleErr_r, idleErr_nxt;
  logic [10:0] aisGood_r, aisGood_nxt, aisBad_r, aisBad_nxt;
  logic [10:0] idleGood_r, idleGood_nxt, idleBad_r, idleBad_nxt;
  logic [1:0] cOnes_r, cOnes_nxt;
  logic ais_r, ais_nxt, idle_r, idle_nxt;
  logic [2:0] e3ZeroCur_r, e3ZeroCur_nxt, e3ZeroPrev_r, e3ZeroPrev_nxt;
  logic [2:0] raiAct_r, raiAct_nxt, raiIn_r, raiIn_nxt;
  logic rai_r, rai_nxt;
  logic synced_r, synced_nxt;
  logic [ALIGN_W-1:0] align_r, align_nxt;
  logic [1:0] idx;
  logic [2:0] aisErrNow, idleErrNow, zCur;
  logic [3:0] pairZeros;
  logic rStrobe, rAct, rInact, cMajority, sefeSet, cofaSet;

  // Latch state
  logic [4:0] alarmL_r, alarmL_nxt, chg_r, chg_nxt, condPrev_r, condPrev_nxt;
  logic [1:0] sof_r, sof_nxt;
  logic [5:0] evL_r, evL_nxt;
  logic [3:0] clrL_r, clrL_nxt;
  logic sn_r, sn_nxt, aic_r, aic_nxt;
  logic [4:0] cond;
  logic [5:0] evSet;
  logic [1:0] sofSet;
  logic losNow, exzEvent, raiOut;

  zero_run_detect u_zero_run (
    .ref_clk(ref_clk),
    .reset(reset),
    .bitValid(rxBit.bitValid),
    .bitVal(rxBit.bitVal),
    .e3Mode(e3Mode),
    .bipolarLine(bipolarLine),
    .signalAbsent(losNow),
    .zeroRunExcess(exzEvent)
  );

  // Register bus: one wait cycle, data captured on the first edge
  assign req = read || write;
  assign waitrequest = req && !ackR;
  assign accept = req && ackR;
  assign stsClr = accept && read && regHit(address, IDX_ALARM_STATUS);
  assign infoClr = accept && read && regHit(address, IDX_EVENT_INFO);

  always_comb begin
    ackNxt = req && !ackR;
    readdataNxt = readdataR;
    maskNxt = maskR;
    masterNxt = masterR;
    if (read && !ackR) begin
      readdataNxt = 32'h0000_0000;
      if (regHit(address, IDX_ALARM_STATUS)) begin
        readdataNxt[MASK_BITS-1:0] = {sof_r, alarmL_r};
      end else if (regHit(address, IDX_ALARM_MASK)) begin
        readdataNxt[15:0] = {RESET_ALARM_MASK[15:MASK_BITS], maskR};
      end else if (regHit(address, IDX_EVENT_INFO)) begin
        readdataNxt[15:0] = {2'h0, clrL_r, aic_r, sn_r, 2'h0, evL_r};
      end else if (regHit(address, IDX_MASTER_MASK)) begin
        readdataNxt[0] = masterR;
      end
    end
    if (accept && write && byteenable[0]) begin
      if (regHit(address, IDX_ALARM_MASK)) begin
        maskNxt = writedata[MASK_BITS-1:0];
      end else if (regHit(address, IDX_MASTER_MASK)) begin
        masterNxt = writedata[0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ackR <= 1'b0;
      readdataR <= 32'h0000_0000;
      maskR <= RESET_ALARM_MASK[MASK_BITS-1:0];
      masterR <= RESET_MASTER_MASK;
    end else begin
      ackR <= ackNxt;
      readdataR <= readdataNxt;
      maskR <= maskNxt;
      masterR <= masterNxt;
    end
  end

  assign readdata = readdataR;

  // Alarm detectors
  always_comb begin
    fHist_nxt = fHist_r;
    mHist_nxt = mHist_r;
    fasBad_nxt = fasBad_r;
    fasGood_nxt = fasGood_r;
    lof_nxt = lof_r;
    bitIdx_nxt = bitIdx_r;
    aisErr_nxt = aisErr_r;
    idleErr_nxt = idleErr_r;
    aisGood_nxt = aisGood_r;
    aisBad_nxt = aisBad_r;
    idleGood_nxt = idleGood_r;
    idleBad_nxt = idleBad_r;
    cOnes_nxt = cOnes_r;
    ais_nxt = ais_r;
    idle_nxt = idle_r;
    e3ZeroCur_nxt = e3ZeroCur_r;
    e3ZeroPrev_nxt = e3ZeroPrev_r;
    raiAct_nxt = raiAct_r;
    raiIn_nxt = raiIn_r;
    rai_nxt = rai_r;
    synced_nxt = synced_r;
    align_nxt = align_r;
    sefeSet = 1'b0;
    cofaSet = 1'b0;
    pairZeros = 4'h0;
    idx = rxBit.fieldStart ? 2'h0 : bitIdx_r;
    // Pattern 10 starts with the 1 after the overhead bit, 1100 with its 11
    aisErrNow = errInc(rxBit.fieldStart ? 3'h0 : aisErr_r, rxBit.bitVal == idx[0]);
    idleErrNow = errInc(rxBit.fieldStart ? 3'h0 : idleErr_r, rxBit.bitVal == idx[1]);
    zCur = ovh.frameStart ? 3'h0 : e3ZeroCur_r;
    cMajority = (cOnes_r + {1'b0, ovh.cVal}) >= 2'h2;
    rStrobe = e3Mode ? ovh.bit11Strobe : ovh.xStrobe;
    rAct = e3Mode ? ovh.bit11 : (!ovh.x1 && !ovh.x2);
    rInact = e3Mode ? !ovh.bit11 : (ovh.x1 && ovh.x2);

    if (!e3Mode && rxBit.bitValid && rxBit.payload) begin
      bitIdx_nxt = idx + 2'h1;
      aisErr_nxt = aisErrNow;
      idleErr_nxt = idleErrNow;
      if (rxBit.fieldEnd) begin
        if (aisErrNow < FIELD_ERR_LIMIT) begin
          aisGood_nxt = runInc(aisGood_r);
          aisBad_nxt = 11'h000;
        end else begin
          aisBad_nxt = runInc(aisBad_r);
          aisGood_nxt = 11'h000;
        end
        if (idleErrNow < FIELD_ERR_LIMIT) begin
          idleGood_nxt = runInc(idleGood_r);
          idleBad_nxt = 11'h000;
        end else begin
          idleBad_nxt = runInc(idleBad_r);
          idleGood_nxt = 11'h000;
        end
      end
    end
    // A C group decoding to one restarts the good-field run
    if (!e3Mode && ovh.cStrobe) begin
      if (ovh.cIdx == C_LAST_IDX) begin
        cOnes_nxt = 2'h0;
        if (cMajority) begin
          aisGood_nxt = 11'h000;
          if (ovh.subframe == C_SUBFRAME_IDLE) begin
            idleGood_nxt = 11'h000;
          end
        end
      end else begin
        cOnes_nxt = cOnes_r + {1'b0, ovh.cVal};
      end
    end
    if (!e3Mode) begin
      if (aisGood_r == FIELD_RUN_LEN) begin
        ais_nxt = 1'b1;
      end else if (aisBad_r == FIELD_RUN_LEN) begin
        ais_nxt = 1'b0;
      end
      if (idleGood_r == FIELD_RUN_LEN) begin
        idle_nxt = 1'b1;
      end else if (idleBad_r == FIELD_RUN_LEN) begin
        idle_nxt = 1'b0;
      end
    end else begin
      idle_nxt = 1'b0;
      if (rxBit.bitValid) begin
        if (ovh.frameStart) begin
          pairZeros = {1'b0, e3ZeroPrev_r} + {1'b0, e3ZeroCur_r};
          ais_nxt = (pairZeros <= E3_AIS_MAX_ZEROS);
          e3ZeroPrev_nxt = e3ZeroCur_r;
        end
        e3ZeroCur_nxt = rxBit.bitVal ? zCur : inc3(zCur, E3_ZERO_SAT);
      end
    end

    if (!e3Mode) begin
      if (ovh.fStrobe) begin
        fHist_nxt = {fHist_r[14:0], ovh.fErr};
        if (ones16(fHist_nxt) >= F_ERR_LIMIT) begin
          lof_nxt = 1'b1;
          sefeSet = 1'b1;
        end
      end
      if (ovh.mStrobe) begin
        mHist_nxt = {mHist_r[2:0], ovh.mErr};
        if (ones16({12'h000, mHist_nxt}) >= M_ERR_LIMIT) begin
          lof_nxt = 1'b1;
        end
      end
      if (syncAchieved) begin
        lof_nxt = 1'b0;
        fHist_nxt = 16'h0000;
        mHist_nxt = 4'h0;
      end
    end else if (ovh.fasStrobe) begin
      if (ovh.fasGood) begin
        fasBad_nxt = 3'h0;
        fasGood_nxt = inc3(fasGood_r, E3_LOF_GOOD);
        if (fasGood_r + 3'h1 == E3_LOF_GOOD) begin
          lof_nxt = 1'b0;
        end
      end else begin
        fasGood_nxt = 3'h0;
        fasBad_nxt = inc3(fasBad_r, E3_LOF_BAD);
        if (fasBad_r + 3'h1 == E3_LOF_BAD) begin
          lof_nxt = 1'b1;
          sefeSet = 1'b1;
        end
      end
    end

    if (rStrobe) begin
      raiAct_nxt = rAct ? inc3(raiAct_r, RAI_RUN) : 3'h0;
      raiIn_nxt = rInact ? inc3(raiIn_r, RAI_RUN) : 3'h0;
      if (rAct && (raiAct_r + 3'h1 == RAI_RUN)) begin
        rai_nxt = 1'b1;
      end
      if (rInact && (raiIn_r + 3'h1 == RAI_RUN)) begin
        rai_nxt = 1'b0;
      end
    end

    // Resync pulses arrive only after a loss, so one flag per realignment
    if (syncAchieved) begin
      cofaSet = synced_r && (syncAlign != align_r);
      synced_nxt = 1'b1;
      align_nxt = syncAlign;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fHist_r <= 16'h0000;
      mHist_r <= 4'h0;
      fasBad_r <= 3'h0;
      fasGood_r <= 3'h0;
      lof_r <= 1'b0;
      bitIdx_r <= 2'h0;
      aisErr_r <= 3'h0;
      idleErr_r <= 3'h0;
      aisGood_r <= 11'h000;
      aisBad_r <= 11'h000;
      idleGood_r <= 11'h000;
      idleBad_r <= 11'h000;
      cOnes_r <= 2'h0;
      ais_r <= 1'b0;
      idle_r <= 1'b0;
      e3ZeroCur_r <= E3_ZERO_SAT;
      e3ZeroPrev_r <= E3_ZERO_SAT;
      raiAct_r <= 3'h0;
      raiIn_r <= 3'h0;
      rai_r <= 1'b0;
      synced_r <= 1'b0;
      align_r <= '0;
    end else begin
      fHist_r <= fHist_nxt;
      mHist_r <= mHist_nxt;
      fasBad_r <= fasBad_nxt;
      fasGood_r <= fasGood_nxt;
      lof_r <= lof_nxt;
      bitIdx_r <= bitIdx_nxt;
      aisErr_r <= aisErr_nxt;
      idleErr_r <= idleErr_nxt;
      aisGood_r <= aisGood_nxt;
      aisBad_r <= aisBad_nxt;
      idleGood_r <= idleGood_nxt;
      idleBad_r <= idleBad_nxt;
      cOnes_r <= cOnes_nxt;
      ais_r <= ais_nxt;
      idle_r <= idle_nxt;
      e3ZeroCur_r <= e3ZeroCur_nxt;
      e3ZeroPrev_r <= e3ZeroPrev_nxt;
      raiAct_r <= raiAct_nxt;
      raiIn_r <= raiIn_nxt;
      rai_r <= rai_nxt;
      synced_r <= synced_nxt;
      align_r <= align_nxt;
    end
  end

  // Status latches; a set in the clearing cycle wins, unread bits are kept except in chg_r, which any status read clears whole
  assign raiOut = rai_r || (cbitParity && !e3Mode && feacRai);
  assign cond = {idle_r, raiOut, ais_r, lof_r, losNow};
  assign sofSet = {rxBit.bitValid && ovh.frameStart, txFrameStart};
  assign evSet = {sefeSet, exzEvent, !e3Mode && ovh.mStrobe && ovh.mErr,
                  e3Mode ? (ovh.fasStrobe && !ovh.fasGood) : (ovh.fStrobe && ovh.fErr),
                  zeroSubWord, cofaSet};

  always_comb begin
    alarmL_nxt = cond | (alarmL_r & ~({5{stsClr}} & readdataR[4:0]));
    sof_nxt = sofSet | (sof_r & ~({2{stsClr}} & readdataR[ST_RX_FRAME_START:ST_TX_FRAME_START]));
    chg_nxt = (cond ^ condPrev_r) | (chg_r & ~{5{stsClr}});
    condPrev_nxt = cond;
    evL_nxt = evSet | (evL_r & ~({6{infoClr}} & readdataR[IN_SEVERE_FRAMING_EVENT:IN_ALIGNMENT_CHANGED]));
    clrL_nxt = (condPrev_r[3:0] & ~cond[3:0]) |
               (clrL_r & ~({4{infoClr}} & readdataR[IN_FAR_END_ALARM_CLEARED:IN_SIGNAL_RESTORED]));
    sn_nxt = (e3Mode && rxBit.bitValid && ovh.frameStart) ? ovh.snBit : sn_r;
    aic_nxt = appIdChannel;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      alarmL_r <= 5'h00;
      sof_r <= 2'h0;
      chg_r <= 5'h00;
      condPrev_r <= 5'h00;
      evL_r <= 6'h00;
      clrL_r <= 4'h0;
      sn_r <= 1'b0;
      aic_r <= 1'b0;
    end else begin
      alarmL_r <= alarmL_nxt;
      sof_r <= sof_nxt;
      chg_r <= chg_nxt;
      condPrev_r <= condPrev_nxt;
      evL_r <= evL_nxt;
      clrL_r <= clrL_nxt;
      sn_r <= sn_nxt;
      aic_r <= aic_nxt;
    end
  end

  // Information bits stay out of the interrupt term
  assign irq = masterR && |(maskR & {sof_r, chg_r});
  assign signalAbsent = losNow;
  assign frameLost = lof_r;
  assign upstreamAlarm = ais_r;
  assign farEndAlarm = raiOut;
  assign idlePatternSeen = idle_r;
endmodule

// >>> testbench/t3e3_alarm_chk.sv
// Concurrent checks on the receive alarm block.
// Assumes a bind to the top module; sees only its ports.
`timescale 1ns/1ps
module t3e3_alarm_chk import t3e3_alarm_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire rx_bit_s rxBit,
  input wire ovh_s ovh,
  input wire logic e3Mode,
  input wire logic bipolarLine,
  input wire logic cbitParity,
  input wire logic feacRai,
  input wire logic syncAchieved,
  input wire logic signalAbsent,
  input wire logic frameLost,
  input wire logic farEndAlarm,
  input wire logic idlePatternSeen
);
  logic raiStb, raiOn, raiOff;
  logic [2:0] onCnt_r, offCnt_r;
  logic [7:0] zeroCnt_r;
  assign raiStb = e3Mode ? ovh.bit11Strobe : ovh.xStrobe;
  assign raiOn = e3Mode ? ovh.bit11 : !ovh.x1 && !ovh.x2;
  assign raiOff = e3Mode ? !ovh.bit11 : ovh.x1 && ovh.x2;
  // Far-end strobe runs and zero runs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      onCnt_r <= 3'h0;
      offCnt_r <= 3'h0;
      zeroCnt_r <= 8'h00;
    end else begin
      if (raiStb) begin
        onCnt_r <= raiOn ? onCnt_r + 3'(onCnt_r < 3'h4) : 3'h0;
        offCnt_r <= raiOff ? offCnt_r + 3'(offCnt_r < 3'h4) : 3'h0;
      end
      if (rxBit.bitValid) begin
        zeroCnt_r <= rxBit.bitVal ? 8'h00 : zeroCnt_r + 8'(zeroCnt_r != 8'hFF);
      end
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("long wait");
  chk_upper_zero: assert property (read && !waitrequest |-> readdata[31:16] == 16'h0000)
    else $error("upper half set");
  chk_los_unipolar: assert property (!bipolarLine [*2] |-> !signalAbsent)
    else $error("absent on unipolar");
  chk_idle_e3: assert property (e3Mode [*2] |-> !idlePatternSeen)
    else $error("idle in E3");
  chk_far_end_alarm_channel_rai: assert property (cbitParity && feacRai && !e3Mode |-> farEndAlarm)
    else $error("channel alarm missed");
  chk_lof_sync: assert property (syncAchieved && !e3Mode && !ovh.fStrobe && !ovh.mStrobe
    |-> ##[1:2] !frameLost)
    else $error("sync left frame lost");
  chk_rai_set: assert property (raiStb && raiOn && onCnt_r == 3'h3
    |-> ##[1:2] farEndAlarm)
    else $error("far-end not set");
  chk_rai_clear: assert property (raiStb && raiOff && offCnt_r == 3'h3 && !feacRai
    |-> ##[1:2] !farEndAlarm)
    else $error("far-end not cleared");
  chk_los_set: assert property (rxBit.bitValid && !rxBit.bitVal && zeroCnt_r == 8'hBF
    && bipolarLine |-> ##[1:2] signalAbsent)
    else $error("absent not set");
endmodule
bind t3e3_alarm_detect_status t3e3_alarm_chk chk (.ref_clk(ref_clk), .reset(reset),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .rxBit(rxBit), .ovh(ovh), .e3Mode(e3Mode), .bipolarLine(bipolarLine),
  .cbitParity(cbitParity), .feacRai(feacRai), .syncAchieved(syncAchieved),
  .signalAbsent(signalAbsent), .frameLost(frameLost), .farEndAlarm(farEndAlarm),
  .idlePatternSeen(idlePatternSeen));

// >>> testbench/t3e3_line_model.sv
// Line model: a bit each cycle, 16-cycle frames with overhead strobes.
// Assumes the bench steers zeros, far-end alarm and F errors.
`timescale 1ns/1ps
module t3e3_line_model import t3e3_alarm_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic e3Mode,
  input wire logic zeroLine,
  input wire logic raiActive,
  input wire logic fErrOn,
  output rx_bit_s rxBit,
  output ovh_s ovh
);
  logic [3:0] pos_r;
  always_ff @(posedge ref_clk) begin
    pos_r <= reset ? 4'h0 : pos_r + 4'h1;
  end
  always_comb begin
    rxBit = '0;
    ovh = '0;
    rxBit.bitValid = !reset;
    rxBit.bitVal = !zeroLine;
    ovh.frameStart = !reset && pos_r == 4'h0;
    ovh.fStrobe = !reset && !e3Mode && pos_r == 4'h3;
    ovh.fErr = fErrOn;
    ovh.xStrobe = !reset && !e3Mode && pos_r == 4'h5;
    ovh.x1 = !raiActive;
    ovh.x2 = !raiActive;
    ovh.fasStrobe = !reset && e3Mode && pos_r == 4'h3;
    ovh.fasGood = 1'b1;
    ovh.bit11Strobe = !reset && e3Mode && pos_r == 4'h5;
    ovh.bit11 = raiActive;
  end
endmodule

// >>> testbench/t3e3_alarm_detect_status_tb.sv
// Self-checking bench: register tasks and receive alarm scenarios.
// Assumes the line model supplies the framed receive stream.
`timescale 1ns/1ps
module t3e3_alarm_detect_status_tb import t3e3_alarm_pkg::*;;
  localparam stAddr = IDX_ALARM_STATUS;
  localparam maskAddr = IDX_ALARM_MASK;
  localparam infoAddr = IDX_EVENT_INFO;
  localparam mstAddr = IDX_MASTER_MASK;
  logic ref_clk = 1'b0, reset = 1'b1;
  logic read = 1'b0, write = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic [31:0] writedata = '0;
  logic [31:0] readdata, rd;
  logic waitrequest, irq, signalAbsent, frameLost, upstreamAlarm, farEndAlarm, idleSeen;
  logic e3Mode = 1'b0, cbitParity = 1'b0, feacRai = 1'b0, syncAchieved = 1'b0;
  logic [ALIGN_W-1:0] syncAlign = '0;
  logic zeroLine = 1'b0, raiActive = 1'b0, fErrOn = 1'b0, bipolarLine = 1'b1;
  rx_bit_s rxBit;
  ovh_s ovh;
  int fail_count = 0, total_checks = 0, cycles = 0;
  always #50 ref_clk = ~ref_clk;
  t3e3_line_model line (.ref_clk(ref_clk), .reset(reset), .e3Mode(e3Mode),
    .zeroLine(zeroLine), .raiActive(raiActive), .fErrOn(fErrOn), .rxBit(rxBit), .ovh(ovh));
  t3e3_alarm_detect_status uut (.ref_clk(ref_clk), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .rxBit(rxBit), .ovh(ovh),
    .e3Mode(e3Mode), .bipolarLine(bipolarLine), .cbitParity(cbitParity),
    .feacRai(feacRai), .txFrameStart(1'b0), .zeroSubWord(1'b0), .appIdChannel(1'b0),
    .syncAchieved(syncAchieved), .syncAlign(syncAlign), .irq(irq),
    .signalAbsent(signalAbsent), .frameLost(frameLost), .upstreamAlarm(upstreamAlarm),
    .farEndAlarm(farEndAlarm), .idlePatternSeen(idleSeen));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Held until waitrequest is low at an edge; data taken there
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    read <= !wr;
    write <= wr;
    address <= {a, 2'b00};
    writedata <= d;
    do @(posedge ref_clk); while (waitrequest);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic sync(input logic [ALIGN_W-1:0] al);
    @(posedge ref_clk);
    syncAchieved <= 1'b1;
    syncAlign <= al;
    @(posedge ref_clk);
    syncAchieved <= 1'b0;
    step(3);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    bus(0, maskAddr, 0);
    check("mask reset", 32'h0000_0080, rd);
    bus(0, 8'h00, 0);
    check("unmapped", 32'h0000_0000, rd);
    bus(1, maskAddr, 32'h0000_0008);
    bus(0, maskAddr, 0);
    check("mask rw", 32'h0000_0088, rd);
    for (int m = 0; m < 2; m++) begin
      bus(1, mstAddr, 0);
      @(posedge ref_clk);
      e3Mode <= m[0];
      raiActive <= 1'b1;
      step(100);
      check("far end set", 1, farEndAlarm);
      check("upstream", m[0], upstreamAlarm);
      check("irq master off", 0, irq);
      bus(1, mstAddr, 1);
      check("irq master on", 1, irq);
      bus(1, maskAddr, 0);
      check("irq masked", 0, irq);
      bus(1, maskAddr, 32'h0000_0008);
      check("irq unmasked", 1, irq);
      bus(0, stAddr, 0);
      check("status latch", 1, rd[3]);
      check("irq after read", 0, irq);
      bus(0, stAddr, 0);
      check("status present", 1, rd[3]);
      @(posedge ref_clk);
      raiActive <= 1'b0;
      step(100);
      check("far end clear", 0, farEndAlarm);
      check("irq on clear", 1, irq);
      bus(0, stAddr, 0);
      check("status held", 1, rd[3]);
      bus(0, stAddr, 0);
      check("status gone", 0, rd[3]);
      bus(0, infoAddr, 0);
      check("clear event", 1, rd[13]);
      @(posedge ref_clk);
      zeroLine <= 1'b1;
      step(200);
      check("los set", 1, signalAbsent);
      check("upstream gone", 0, upstreamAlarm);
      check("info no irq", 0, irq);
      bus(0, infoAddr, 0);
      check("zero excess", 1, rd[4]);
      @(posedge ref_clk);
      zeroLine <= 1'b0;
      step(250);
      check("los clear", 0, signalAbsent);
    end
    @(posedge ref_clk);
    e3Mode <= 1'b0;
    bipolarLine <= 1'b0;
    zeroLine <= 1'b1;
    cbitParity <= 1'b1;
    feacRai <= 1'b1;
    step(200);
    check("unipolar", 0, signalAbsent);
    check("far_end_alarm_channel", 1, farEndAlarm);
    @(posedge ref_clk);
    bipolarLine <= 1'b1;
    zeroLine <= 1'b0;
    feacRai <= 1'b0;
    fErrOn <= 1'b1;
    step(80);
    check("lof set", 1, frameLost);
    @(posedge ref_clk);
    fErrOn <= 1'b0;
    step(300);
    sync(11'h005);
    check("lof clear", 0, frameLost);
    bus(0, infoAddr, 0);
    check("first sync", 0, rd[0]);
    sync(11'h006);
    bus(0, infoAddr, 0);
    check("align change", 1, rd[0]);
    bus(0, infoAddr, 0);
    check("align read clr", 0, rd[0]);
    conclude();
  end
endmodule
